// *** rtl/slew_pkg.sv ***
// shared constants and types for the core rail transition control
package slew_pkg;
  localparam logic [7:0] SLEW_ADDR = 8'h1A;
  localparam logic [7:0] SLEW_RESET = 8'h06;
  localparam logic [7:0] BUCK_A_ADDR = 8'h01;
  localparam logic [7:0] BUCK_B_ADDR = 8'h02;
  localparam logic [5:0] BUCK_A_RESET = 6'h00;
  localparam logic [5:0] BUCK_B_RESET = 6'h19;
  localparam int LAUNCH_BIT = 7;
  localparam int BYPASS_BIT = 6;
  localparam int CLK_NS = 100;
  localparam int STEP0_NS = 160000;
  localparam logic [2:0] RATE_NOW = 3'h7;
  localparam logic [10:0] STEP0_CYC = 11'(STEP0_NS / CLK_NS);
  localparam logic [7:0] RSV_MASK = 8'h38;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_STEP = 2'b11
  } ramp_e;
endpackage : slew_pkg

// *** rtl/core_rail_voltage_transition_ctrl.sv ***
// core buck set-point transition sequencer with slew pacing
//
// Function
// - only the two core bucks are ramped here; other rails are untouched.
// - writing 1 to the launch bit ramps both bucks to stored set-points.
// - the launch bit self-clears once the ramp completes.
// - with bypass set, a set-point write starts the ramp directly.
// - ramps are paced by the slew field in both launch and bypass modes.
// - transition register at 0x1A resets to 0x06, bits 5..3 read zero.
// - slew code n gives 160 us over 2^n per step, code 7 is immediate.
`timescale 1ns/1ps
module core_rail_voltage_transition_ctrl
  import slew_pkg::*;
#(
  parameter int CODE_W = 6
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire reg_req_s req,
  output logic [7:0] rdata,
  output logic [CODE_W-1:0] buck_a_out,
  output logic [CODE_W-1:0] buck_b_out,
  output logic busy
);
  // ==========================================================
  // register file
  logic [7:0] slew_reg;
  logic [CODE_W-1:0] seta_reg;
  logic [CODE_W-1:0] setb_reg;
  logic pend_reg;
  logic done;
  ramp_e state_reg;
  logic wr_slew;
  logic wr_set;

  assign wr_slew = req.wr && req.addr == SLEW_ADDR;
  assign wr_set = req.wr &&
    (req.addr == BUCK_A_ADDR || req.addr == BUCK_B_ADDR);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slew_reg <= SLEW_RESET;
    end else if (clk_en) begin
      if (wr_slew) begin
        slew_reg[6:0] <= req.wdata[6:0] & ~RSV_MASK[6:0];
        // launch may only be set by software, never cleared
        if (req.wdata[LAUNCH_BIT]) begin
          slew_reg[LAUNCH_BIT] <= 1'b1;
        end else if (done) begin
          slew_reg[LAUNCH_BIT] <= 1'b0;
        end
      end else if (done) begin
        slew_reg[LAUNCH_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seta_reg <= BUCK_A_RESET[CODE_W-1:0];
      setb_reg <= BUCK_B_RESET[CODE_W-1:0];
    end else if (clk_en && req.wr) begin
      // storing alone does not move the output
      if (req.addr == BUCK_A_ADDR) begin
        seta_reg <= req.wdata[CODE_W-1:0];
      end
      if (req.addr == BUCK_B_ADDR) begin
        setb_reg <= req.wdata[CODE_W-1:0];
      end
    end
  end

  // bypass set-point write is remembered on the same edge that stores it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_reg <= 1'b0;
    end else if (clk_en) begin
      pend_reg <= wr_set && slew_reg[BYPASS_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      case (req.addr)
        SLEW_ADDR: rdata <= slew_reg & ~RSV_MASK;
        BUCK_A_ADDR: rdata <= 8'(seta_reg);
        BUCK_B_ADDR: rdata <= 8'(setb_reg);
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // ramp pacing
  function automatic logic [10:0] step_cycles(input logic [2:0] code);
    step_cycles = STEP0_CYC >> code;
  endfunction : step_cycles

  function automatic logic [CODE_W-1:0] step_toward(
    input logic [CODE_W-1:0] cur, input logic [CODE_W-1:0] tgt);
    if (cur < tgt) begin
      step_toward = cur + 1'b1;
    end else if (cur > tgt) begin
      step_toward = cur - 1'b1;
    end else begin
      step_toward = cur;
    end
  endfunction : step_toward

  logic [10:0] tick_reg;
  logic start;
  logic at_tgt;
  assign start = slew_reg[LAUNCH_BIT] || pend_reg;
  assign at_tgt = buck_a_out == seta_reg && buck_b_out == setb_reg;
  assign done = state_reg == ST_STEP && at_tgt;

  // only the core buck outputs are driven here
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      tick_reg <= 11'h000;
      buck_a_out <= BUCK_A_RESET[CODE_W-1:0];
      buck_b_out <= BUCK_B_RESET[CODE_W-1:0];
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_WAIT;
            tick_reg <= 11'h000;
          end
        end
        ST_WAIT: begin
          // immediate code jumps straight to the target
          if (slew_reg[2:0] == RATE_NOW) begin
            buck_a_out <= seta_reg;
            buck_b_out <= setb_reg;
            state_reg <= ST_STEP;
          end else if (at_tgt) begin
            state_reg <= ST_STEP;
          end else if (tick_reg + 11'h001 >=
                       step_cycles(slew_reg[2:0])) begin
            tick_reg <= 11'h000;
            buck_a_out <= step_toward(buck_a_out, seta_reg);
            buck_b_out <= step_toward(buck_b_out, setb_reg);
          end else begin
            tick_reg <= tick_reg + 11'h001;
          end
        end
        ST_STEP: begin
          // targets moved mid-ramp keep ramping, else finish
          state_reg <= at_tgt ? ST_IDLE : ST_WAIT;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else if (clk_en) begin
      busy <= state_reg != ST_IDLE || start;
    end
  end

  // ==========================================================
  // checks
  a_rsv_zero: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (slew_reg & RSV_MASK) == 8'h00)
    else $error("reserved slew bits nonzero");
  a_launch_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    clk_en && slew_reg[LAUNCH_BIT] && !done |=> slew_reg[LAUNCH_BIT])
    else $error("launch bit dropped early");
  a_launch_clear: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    clk_en && done && !(wr_slew && req.wdata[LAUNCH_BIT])
    |=> !slew_reg[LAUNCH_BIT])
    else $error("launch bit not cleared");
  a_launch_set: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    clk_en && wr_slew && req.wdata[LAUNCH_BIT] |=> slew_reg[LAUNCH_BIT])
    else $error("launch write ignored");
  a_hold_store: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_reg == ST_IDLE && !start && !pend_reg && clk_en
    && !(wr_set && slew_reg[BYPASS_BIT])
    |=> $stable(buck_a_out) && $stable(buck_b_out))
    else $error("output moved without launch");
  a_bypass_go: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    clk_en && wr_set && slew_reg[BYPASS_BIT] |=> pend_reg)
    else $error("bypass write did not start");
  a_step_size: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    slew_reg[2:0] != RATE_NOW |=>
    (buck_a_out - $past(buck_a_out)) inside {'0, 1, '1})
    else $error("paced step larger than one code");
  a_b_step: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    slew_reg[2:0] != RATE_NOW |=>
    (buck_b_out - $past(buck_b_out)) inside {'0, 1, '1})
    else $error("paced step on buck b larger than one code");
  a_fast_step: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    clk_en && state_reg == ST_WAIT && slew_reg[2:0] == RATE_NOW
    |=> buck_a_out == $past(seta_reg) && buck_b_out == $past(setb_reg))
    else $error("immediate code did not jump");
  // a frozen ramp must resume where it stopped, not skip steps
  a_freeze_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !clk_en |=> $stable(state_reg) && $stable(tick_reg)
    && $stable(buck_a_out) && $stable(slew_reg))
    else $error("state moved with clock enable low");
  a_busy_run: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    clk_en && slew_reg[LAUNCH_BIT] |=> busy)
    else $error("launch pending without busy");
  c_launch: cover property (@(posedge ref_clk) done);
  c_bypass: cover property (@(posedge ref_clk) pend_reg);
  c_fast: cover property (@(posedge ref_clk)
    state_reg == ST_WAIT && slew_reg[2:0] == RATE_NOW);
  c_freeze: cover property (@(posedge ref_clk)
    !clk_en && state_reg == ST_WAIT);
endmodule : core_rail_voltage_transition_ctrl

// *** bench/host_model.sv ***
// host side: register writes and reads over the subaddress port
`timescale 1ns/1ps
module host_model
  import slew_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output reg_req_s req
);
  // ====
  // bus cycles, driven off the sampling edge
  initial req = '0;
  // power-save control sits outside this block
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{1'b1, a, d};
    @(negedge ref_clk);
    req.wr = 1'b0;
  endtask : wr
  // registered read data, so one edge between address and data
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req.addr = a;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd
endmodule : host_model

// *** bench/core_rail_voltage_transition_ctrl_tb.sv ***
// self-checking bench for the core rail transition control
`timescale 1ns/1ps
module core_rail_voltage_transition_ctrl_tb;
  import slew_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  reg_req_s req;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [5:0] a_out;
  logic [5:0] b_out;
  logic busy;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  // ====
  // instances
  core_rail_voltage_transition_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst),
    .clk_en(clk_en), .req(req), .rdata(rdata), .buck_a_out(a_out),
    .buck_b_out(b_out), .busy(busy));
  host_model HOST (.ref_clk(ref_clk), .rdata(rdata), .req(req));
  initial forever #50 ref_clk = ~ref_clk;
  // ====
  // checking and closing
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ramps here stay far below this ceiling
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // cycles until busy drops, bounded
  task automatic ramp_len(output int k);
    k = 0;
    while (busy !== 1'b0 && k < 5000) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : ramp_len
  // ====
  // scenarios
  task automatic t_reset;
    HOST.rd(SLEW_ADDR, rv);
    chk(rv, 8'h06);
    chk({2'b00, a_out}, 8'h00);
    chk({2'b00, b_out}, 8'h19);
    HOST.rd(8'h55, rv);
    chk(rv, 8'h00);
    HOST.wr(SLEW_ADDR, 8'h3E);
    HOST.rd(SLEW_ADDR, rv);
    chk(rv, 8'h06);
  endtask : t_reset
  // rate 6: 25 cycles a step, two steps
  task automatic t_launch;
    HOST.wr(BUCK_A_ADDR, 8'h02);
    repeat (60) @(negedge ref_clk);
    chk({2'b00, a_out}, 8'h00);
    HOST.wr(SLEW_ADDR, 8'h86);
    HOST.rd(SLEW_ADDR, rv);
    chk(rv, 8'h86);
    ramp_len(n);
    chk(8'(n inside {[40:60]}), 8'h01);
    chk({2'b00, a_out}, 8'h02);
    chk({2'b00, b_out}, 8'h19);
    HOST.rd(SLEW_ADDR, rv);
    chk(rv, 8'h06);
  endtask : t_launch
  task automatic t_bypass;
    HOST.wr(SLEW_ADDR, 8'h46);
    HOST.wr(BUCK_B_ADDR, 8'h17);
    HOST.rd(SLEW_ADDR, rv);
    chk(rv, 8'h46);
    ramp_len(n);
    chk(8'(n inside {[40:60]}), 8'h01);
    chk({2'b00, b_out}, 8'h17);
  endtask : t_bypass
  // code 7 skips pacing
  task automatic t_now;
    HOST.wr(SLEW_ADDR, 8'h07);
    HOST.wr(BUCK_A_ADDR, 8'h05);
    HOST.wr(SLEW_ADDR, 8'h87);
    HOST.rd(SLEW_ADDR, rv);
    ramp_len(n);
    chk(8'(n <= 4), 8'h01);
    chk({2'b00, a_out}, 8'h05);
    HOST.rd(SLEW_ADDR, rv);
    chk(rv, 8'h07);
  endtask : t_now
  // rate 5, 50 cycles a step; clock enable low stalls the ramp
  task automatic t_freeze;
    HOST.wr(SLEW_ADDR, 8'h05);
    HOST.wr(BUCK_A_ADDR, 8'h08);
    HOST.wr(SLEW_ADDR, 8'h85);
    repeat (60) @(negedge ref_clk);
    clk_en = 1'b0;
    repeat (100) @(negedge ref_clk);
    chk({2'b00, a_out}, 8'h06);
    chk({7'h00, busy}, 8'h01);
    clk_en = 1'b1;
    ramp_len(n);
    chk(8'(n inside {[88:100]}), 8'h01);
    chk({2'b00, a_out}, 8'h08);
    HOST.rd(SLEW_ADDR, rv);
    chk(rv, 8'h05);
  endtask : t_freeze
  initial begin
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    t_reset();
    t_launch();
    t_bypass();
    t_now();
    t_freeze();
    tally_and_finish();
  end
endmodule : core_rail_voltage_transition_ctrl_tb
